// >>> rtl/ivp_unit.sv
// Interrupt vector and priority unit: vector tables, flags, enables, levels.
// Assumes a classic Wishbone master on clk_i and a core that fetches vectors.
`timescale 1ns/10ps

// What this block does
// - Reset word jumps; next word holds start
// - Traps first: osc, addr, stack, math, DMA
// - Primary vectors 0..117 at two-byte steps
// - Alternate table repeats layout, offset 0x100
// - Lower table position wins among traps and among equal-level sources
module ivp_unit (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [7:0]                    adr_i,
  input  wire logic [31:0]                   dat_i,
  output logic [31:0]                        dat_o,
  output logic                               ack_o,
  output logic                               err_o,
  // Peripheral requests and trap events, one-cycle pulses
  input  wire logic [ivp_pkg::NUM_SRC-1:0]   src_req_i,
  input  wire logic [ivp_pkg::NUM_TRAPS-1:0] trap_req_i,
  // Core vector fetch port
  input  wire logic                          fetch_i,
  input  wire logic [23:0]                   fetch_addr_i,
  output logic [23:0]                        fetch_data_o,
  output logic                               fetch_ack_o,
  // Pending vector to the core
  output ivp_pkg::ivp_vec_t                  vec_o,
  output logic                               irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] flag;   // Source flags
    logic [15:0] en;     // Source enables
    logic [15:0] prio;   // Four 3-bit levels
    logic        alt;    // Alternate table selected
    logic [23:0] start;  // User start address
    logic [ivp_pkg::NUM_TRAPS-1:0] tstat; // Sticky trap status
    logic [ivp_pkg::NUM_TRAPS-1:0] ten;   // Trap status enable
    logic        ack;    // Bus acknowledge
    logic        err;    // Bus error
    logic [31:0] rdat;   // Bus read data
    logic        fack;   // Fetch acknowledge
    logic [23:0] fdat;   // Fetch data
    ivp_pkg::ivp_vec_t vec; // Registered winner
  } ivp_state_t;

  ivp_state_t                              s_q;     // Registered state
  ivp_state_t                              s_d;     // Next state
  ivp_pkg::ivp_wb_req_t                    req;     // Bundled bus request
  logic [ivp_pkg::NUM_SRC*ivp_pkg::LVL_W-1:0] lvl_vec; // Per-source levels
  logic [ivp_pkg::NUM_SRC-1:0]             arm;     // Flag and enable
  logic                                    win_hit; // Source winner valid
  logic [3:0]                              win_idx; // Source winner index
  logic [ivp_pkg::LVL_W-1:0]               win_lvl; // Source winner level
  logic [31:0]                             wmask;   // Byte-lane write mask

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};
  assign wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};

  // ----------------------------------------------------------------
  // Level map: the 16 flag bits reuse the four priority fields
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ivp_pkg::NUM_SRC; i++) begin
      lvl_vec[i*ivp_pkg::LVL_W +: ivp_pkg::LVL_W] = s_q.prio[(i % 4)*4 +: ivp_pkg::LVL_W];
    end
  end

  assign arm = s_q.flag & s_q.en;

  ivp_arbiter u_arb (
    .req_i (arm),
    .lvl_i (lvl_vec),
    .hit_o (win_hit),
    .idx_o (win_idx),
    .lvl_o (win_lvl)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        acc;
    logic        hit;
    logic [23:0] base;
    logic [23:0] off;
    acc  = 1'b0;
    hit  = 1'b0;
    base = 24'h000000;
    off  = 24'h000000;
    s_d  = s_q;

    // Flags: new requests set, win over a clear
    s_d.flag  = s_q.flag | (src_req_i & ivp_pkg::FLAG_MASK);
    s_d.tstat = s_q.tstat | trap_req_i;

    // Bus slave: answer one cycle after the request, then drop
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    acc = req.cyc && req.stb && !s_q.ack && !s_q.err;
    if (acc) begin
      hit = 1'b1;
      s_d.rdat = 32'h00000000;
      unique case (req.adr)
        ivp_pkg::OFF_FLAG: begin
          s_d.rdat = {16'h0000, s_q.flag};
          if (req.we) begin
            // Written zeros clear, fresh requests still set
            s_d.flag = ((s_q.flag & ~wmask[15:0]) | (req.dat[15:0] & wmask[15:0])
                        | src_req_i) & ivp_pkg::FLAG_MASK;
          end
        end
        ivp_pkg::OFF_EN: begin
          s_d.rdat = {16'h0000, s_q.en};
          if (req.we) begin
            s_d.en = ((s_q.en & ~wmask[15:0]) | (req.dat[15:0] & wmask[15:0])) & ivp_pkg::EN_MASK;
          end
        end
        ivp_pkg::OFF_PRIO: begin
          s_d.rdat = {16'h0000, s_q.prio};
          if (req.we) begin
            s_d.prio = ((s_q.prio & ~wmask[15:0]) | (req.dat[15:0] & wmask[15:0])) & ivp_pkg::PRIO_MASK;
          end
        end
        ivp_pkg::OFF_CTRL: begin
          s_d.rdat = {s_q.start, 7'h00, s_q.alt};
          if (req.we && req.sel[0]) begin
            s_d.alt = req.dat[ivp_pkg::CTRL_ALT_BIT];
          end
          if (req.we && &req.sel[3:1]) begin
            s_d.start = req.dat[31:8];
          end
        end
        ivp_pkg::OFF_TSTAT: begin
          s_d.rdat = {27'h0000000, s_q.tstat};
        end
        ivp_pkg::OFF_TCLR: begin
          if (req.we && req.sel[0]) begin
            // Clear by writing one; a same-cycle event stays set
            s_d.tstat = (s_q.tstat & ~req.dat[ivp_pkg::NUM_TRAPS-1:0]) | trap_req_i;
          end
        end
        ivp_pkg::OFF_TEN: begin
          s_d.rdat = {27'h0000000, s_q.ten};
          if (req.we && req.sel[0]) begin
            s_d.ten = req.dat[ivp_pkg::NUM_TRAPS-1:0];
          end
        end
        ivp_pkg::OFF_PEND: begin
          s_d.rdat = {s_q.vec.addr, s_q.vec.valid, s_q.vec.num};
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      s_d.ack = hit;
      s_d.err = !hit;
    end

    // Winner: traps first in fixed order, then sources
    base = s_q.alt ? ivp_pkg::ALTERNATE_VECTOR_TABLE_OFFSET : 24'h000000;
    s_d.vec = '0;
    // Later (lower) index overrides, lowest trap wins; enable gates only irq_o
    for (int t = ivp_pkg::NUM_TRAPS - 1; t >= 0; t--) begin
      if (s_q.tstat[t]) begin
        s_d.vec.valid = 1'b1;
        s_d.vec.trap  = 1'b1;
        s_d.vec.num   = 7'(t);
        s_d.vec.level = 3'h7;
        off           = ivp_pkg::TRAP_BASE_ADDR + 24'(t) * ivp_pkg::VEC_STRIDE;
        s_d.vec.addr  = base + off;
      end
    end
    if (!s_d.vec.valid && win_hit) begin
      s_d.vec.valid = 1'b1;
      s_d.vec.num   = ivp_pkg::SRC_VEC_BASE + 7'(win_idx);
      s_d.vec.level = win_lvl;
      off = ivp_pkg::IVT_VEC0_ADDR + 24'(s_d.vec.num) * ivp_pkg::VEC_STRIDE;
      s_d.vec.addr  = base + off;
    end

    // Vector fetch: reset pair, then table words
    s_d.fack = fetch_i;
    s_d.fdat = 24'h000000;
    if (fetch_i) begin
      if (fetch_addr_i == ivp_pkg::RESET_GOTO_ADDR) begin
        s_d.fdat = ivp_pkg::GOTO_OPCODE;
      end else if (fetch_addr_i == ivp_pkg::RESET_TGT_ADDR) begin
        s_d.fdat = s_q.start;
      end else if ((fetch_addr_i >= ivp_pkg::IVT_VEC0_ADDR && fetch_addr_i <= ivp_pkg::IVT_VEC117_ADDR) ||
                   (fetch_addr_i >= ivp_pkg::ALTERNATE_VECTOR_TABLE_VEC0_ADDR && fetch_addr_i <= ivp_pkg::ALTERNATE_VECTOR_TABLE_VEC117_ADDR)) begin
        // Table slot returns the handler address for that vector
        s_d.fdat = s_q.start + (fetch_addr_i & 24'h0000ff);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.prio  <= ivp_pkg::PRIO5_RST;
      s_q.start <= ivp_pkg::START_ADDR_DFLT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o        = s_q.rdat;
  assign ack_o        = s_q.ack;
  assign err_o        = s_q.err;
  assign fetch_data_o = s_q.fdat;
  assign fetch_ack_o  = s_q.fack;
  assign vec_o        = s_q.vec;
  assign irq_o        = |(s_q.tstat & s_q.ten) || (s_q.vec.valid && !s_q.vec.trap);

endmodule : ivp_unit

// >>> rtl/ivp_pkg.sv
// Package for the interrupt vector and priority unit.
// Assumes a classic Wishbone slave with 32-bit data; flag, enable and priority registers are 16-bit.
package ivp_pkg;

  // ----------------------------------------------------------------
  // Vector table layout (program addresses, byte units)
  // ----------------------------------------------------------------
  localparam logic [23:0] RESET_GOTO_ADDR  = 24'h000000; // Jump instruction word
  localparam logic [23:0] RESET_TGT_ADDR   = 24'h000002; // Jump target word
  localparam logic [23:0] TRAP_BASE_ADDR   = 24'h000006; // First trap vector
  localparam logic [23:0] IVT_VEC0_ADDR    = 24'h000014; // Primary vector 0
  localparam logic [23:0] IVT_VEC117_ADDR  = 24'h0000fe; // Primary vector 117
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_OFFSET      = 24'h000100; // Alternate table offset
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_VEC0_ADDR   = 24'h000114; // Alternate vector 0
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_VEC117_ADDR = 24'h0001fe; // Alternate vector 117
  localparam logic [23:0] VEC_STRIDE       = 24'h000002; // Two bytes per vector
  localparam logic [23:0] GOTO_OPCODE      = 24'h040000; // Jump opcode word
  localparam logic [23:0] START_ADDR_DFLT  = 24'h000200; // Default user start

  // ----------------------------------------------------------------
  // Trap ids in fixed natural order
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TRAP_OSC   = 3'h0,
    TRAP_ADDR  = 3'h1,
    TRAP_STACK = 3'h2,
    TRAP_MATH  = 3'h3,
    TRAP_DMA   = 3'h4
  } ivp_trap_t;
  localparam int NUM_TRAPS = 5;

  // ----------------------------------------------------------------
  // Sources and register geometry
  // ----------------------------------------------------------------
  localparam int NUM_SRC  = 16;       // Sources of one flag group
  localparam int LVL_W    = 3;        // Priority field width
  localparam logic [2:0] LVL_OFF = 3'h0; // Priority zero disables
  localparam logic [6:0] SRC_VEC_BASE = 7'h30; // Vector number of source 0
  localparam logic [15:0] PRIO5_RST = 16'h4444; // Priority register reset
  localparam logic [15:0] FLAG_MASK = 16'hfffb; // Implemented flag bits
  localparam logic [15:0] EN_MASK   = 16'h39ff; // Implemented enable bits
  localparam logic [15:0] PRIO_MASK = 16'h7777; // Implemented priority bits

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FLAG   = 8'h00; // interrupt_flag_status_group
  localparam logic [7:0] OFF_EN     = 8'h04; // interrupt_enable_control_3
  localparam logic [7:0] OFF_PRIO   = 8'h08; // interrupt_priority_control_5
  localparam logic [7:0] OFF_CTRL   = 8'h0c; // Table select and start address
  localparam logic [7:0] OFF_TSTAT  = 8'h10; // Sticky trap status, read only
  localparam logic [7:0] OFF_TCLR   = 8'h14; // Trap status clear, write only
  localparam logic [7:0] OFF_TEN    = 8'h18; // Trap status enable
  localparam logic [7:0] OFF_PEND   = 8'h1c; // Winning vector, read only
  localparam int CTRL_ALT_BIT = 0;          // Alternate table select

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ivp_wb_req_t;

  typedef struct packed {
    logic        valid; // A source or trap is pending
    logic        trap;  // Winner is a trap
    logic [6:0]  num;   // Trap id or interrupt vector number
    logic [2:0]  level; // Priority level, 7 for traps
    logic [23:0] addr;  // Program address of the vector
  } ivp_vec_t;

endpackage : ivp_pkg

// >>> rtl/ivp_arbiter.sv
// Level-first priority arbiter over the interrupt sources, natural order on a tie.
// Assumes same-clock inputs; output is combinational.
`timescale 1ns/10ps
module ivp_arbiter (
  // Requests
  input  wire logic [ivp_pkg::NUM_SRC-1:0]            req_i,
  input  wire logic [ivp_pkg::NUM_SRC*ivp_pkg::LVL_W-1:0] lvl_i,
  // Winner
  output logic                                         hit_o,
  output logic [3:0]                                   idx_o,
  output logic [ivp_pkg::LVL_W-1:0]                    lvl_o
);

  // ----------------------------------------------------------------
  // Scan: higher level wins, lower index wins a tie
  // ----------------------------------------------------------------
  always_comb begin
    hit_o = 1'b0;
    idx_o = 4'h0;
    lvl_o = ivp_pkg::LVL_OFF;
    for (int i = ivp_pkg::NUM_SRC - 1; i >= 0; i--) begin
      // Later (lower) index overrides on equal level
      if (req_i[i] && lvl_i[i*ivp_pkg::LVL_W +: ivp_pkg::LVL_W] >= lvl_o &&
          lvl_i[i*ivp_pkg::LVL_W +: ivp_pkg::LVL_W] != ivp_pkg::LVL_OFF) begin
        hit_o = 1'b1;
        idx_o = 4'(i);
        lvl_o = lvl_i[i*ivp_pkg::LVL_W +: ivp_pkg::LVL_W];
      end
    end
  end

endmodule : ivp_arbiter

// >>> verification/ivp_unit_properties.sv
// Concurrent checks on the ports of the interrupt vector unit.
// Assumes it is bound to ivp_unit from the bench top file.
`timescale 1ns/10ps
module ivp_unit_properties (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // Bus
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic [7:0]        adr_i,
  input wire logic              ack_o,
  input wire logic              err_o,
  // Events and core port
  input wire logic [4:0]        trap_req_i,
  input wire logic              fetch_i,
  input wire logic [23:0]       fetch_addr_i,
  input wire logic [23:0]       fetch_data_o,
  input wire logic              fetch_ack_o,
  input wire ivp_pkg::ivp_vec_t vec_o,
  input wire logic              irq_o
);
  // ----------------------------------------------------------------
  // Common clock and reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Request taken, then one answer that drops next cycle
  sequence s_taken;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_answer;
    (ack_o ^ err_o) ##1 !(ack_o || err_o);
  endsequence

  property p_bus_answer;
    s_taken |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer missing or too long");
  property p_err_unmapped;
    s_taken and (adr_i > 8'h1f) |=> err_o && !ack_o;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_fetch_ack;
    fetch_i |=> fetch_ack_o;
  endproperty
  a_fetch_ack: assert property (p_fetch_ack) else $error("fetch not answered next cycle");
  property p_fetch_goto;
    fetch_i && (fetch_addr_i == ivp_pkg::RESET_GOTO_ADDR) |=> fetch_data_o == ivp_pkg::GOTO_OPCODE;
  endproperty
  a_fetch_goto: assert property (p_fetch_goto) else $error("reset word is not a jump");
  property p_src_addr;
    vec_o.valid && !vec_o.trap |-> vec_o.addr[23:9] == 15'h0000 && vec_o.num <= 7'h75
      && vec_o.addr[7:0] == {vec_o.num, 1'b0} + 8'h14;
  endproperty
  a_src_addr: assert property (p_src_addr) else $error("source vector address wrong");
  property p_src_level;
    vec_o.valid && !vec_o.trap |-> vec_o.level != ivp_pkg::LVL_OFF && irq_o;
  endproperty
  a_src_level: assert property (p_src_level) else $error("disabled level won");
  property p_trap_vec;
    vec_o.valid && vec_o.trap |-> vec_o.level == 3'h7 && vec_o.num < 7'h05
      && vec_o.addr[23:9] == 15'h0000 && vec_o.addr[7:0] == {vec_o.num, 1'b0} + 8'h06;
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
  property p_trap_wins;
    trap_req_i != 5'h00 |-> ##2 (vec_o.valid && vec_o.trap);
  endproperty
  a_trap_wins: assert property (p_trap_wins) else $error("trap did not outrank sources");
endmodule : ivp_unit_properties

// >>> verification/ivp_core_model.sv
// Model of the processor core that fetches vector words.
// Assumes the bench calls fetch and one fetch runs at a time.
`timescale 1ns/10ps
module ivp_core_model (
  // Clock
  input  wire logic        clk_i,
  // Fetch port
  output logic             fetch_o,
  output logic [23:0]      fetch_addr_o,
  input  wire logic [23:0] fetch_data_i,
  input  wire logic        fetch_ack_i
);
  // Idle at time zero
  initial begin
    fetch_o      = 1'b0;
    fetch_addr_o = 24'hffffff;
  end

  // Hold the strobe until the answer is seen, then release
  task automatic fetch(input logic [23:0] addr, output logic [23:0] data);
    int n;
    @(posedge clk_i);
    fetch_o      <= 1'b1;
    fetch_addr_o <= addr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fetch_ack_i !== 1'b1 && n < 50);
    data = fetch_data_i;
    fetch_o      <= 1'b0;
    fetch_addr_o <= ~addr; // Released address shows no stale value
  endtask : fetch
endmodule : ivp_core_model

// >>> verification/ivp_unit_bench.sv
// Self-checking bench for the interrupt vector unit.
// Assumes the package and the design files are compiled before it.
`timescale 1ns/10ps
module ivp_unit_bench;
  logic clk_i, rst_i, cyc, stb, we, irq_o, ack_o, err_o, fetch_i, fetch_ack_o;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] dat, dat_o, r;
  logic [15:0] src;
  logic [4:0]  trp;
  logic [23:0] fadr, fdat, fd;
  logic        er;
  ivp_pkg::ivp_vec_t vec_o;
  int num_errors, checks_done;

  ivp_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
    .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .src_req_i(src),
    .trap_req_i(trp), .fetch_i(fetch_i), .fetch_addr_i(fadr), .fetch_data_o(fdat),
    .fetch_ack_o(fetch_ack_o), .vec_o(vec_o), .irq_o(irq_o));
  ivp_core_model i_core (.clk_i(clk_i), .fetch_o(fetch_i), .fetch_addr_o(fadr),
    .fetch_data_i(fdat), .fetch_ack_i(fetch_ack_o));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Classic single cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'hf, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    r  = dat_o;
    er = err_o;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    check(nm, r, e);
  endtask : rd
  task automatic pulse(input logic [15:0] s, input logic [4:0] t);
    @(posedge clk_i);
    src <= s;
    trp <= t;
    @(posedge clk_i);
    src <= 16'h0000;
    trp <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, cyc, stb, we, sel, adr, dat, src, trp} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ivp_pkg::OFF_PRIO, {16'h0000, ivp_pkg::PRIO5_RST}, "priority reset");
    rd(ivp_pkg::OFF_EN, 32'h0, "enable reset");
    i_core.fetch(ivp_pkg::RESET_GOTO_ADDR, fd);
    check("jump word", {8'h00, fd}, {8'h00, ivp_pkg::GOTO_OPCODE});
    i_core.fetch(ivp_pkg::RESET_TGT_ADDR, fd);
    check("start word", {8'h00, fd}, {8'h00, ivp_pkg::START_ADDR_DFLT});
    wb(1'b1, ivp_pkg::OFF_CTRL, 32'h00040000);
    i_core.fetch(ivp_pkg::RESET_TGT_ADDR, fd);
    check("moved start", {8'h00, fd}, 32'h00000400);
    // Masked event sets its flag only
    pulse(16'h0001, 5'h00);
    rd(ivp_pkg::OFF_FLAG, 32'h1, "flag set");
    check("irq masked", {31'h0, irq_o}, 32'h0);
    // Equal levels: lower vector wins
    wb(1'b1, ivp_pkg::OFF_EN, 32'h3);
    pulse(16'h0002, 5'h00);
    rd(ivp_pkg::OFF_PEND, {24'h000074, 1'b1, 7'h30}, "tie winner");
    check("irq enabled", {31'h0, irq_o}, 32'h1);
    wb(1'b1, ivp_pkg::OFF_PRIO, 32'h4464);
    rd(ivp_pkg::OFF_PEND, {24'h000076, 1'b1, 7'h31}, "higher level");
    wb(1'b1, ivp_pkg::OFF_PRIO, 32'h4400);
    rd(ivp_pkg::OFF_PRIO, 32'h4400, "priority write");
    check("irq level zero", {31'h0, irq_o}, 32'h0);
    wb(1'b1, ivp_pkg::OFF_PRIO, 32'h4444);
    wb(1'b1, ivp_pkg::OFF_CTRL, 32'h00040001);
    rd(ivp_pkg::OFF_PEND, {24'h000174, 1'b1, 7'h30}, "alternate vector");
    wb(1'b1, ivp_pkg::OFF_CTRL, 32'h00040000);
    wb(1'b1, ivp_pkg::OFF_FLAG, 32'h2);
    rd(ivp_pkg::OFF_FLAG, 32'h2, "flag write zero");
    // All traps beside a source: traps win in fixed order
    pulse(16'h0000, 5'h1f);
    wb(1'b1, ivp_pkg::OFF_TSTAT, 32'h0);
    rd(ivp_pkg::OFF_TSTAT, 32'h1f, "trap status");
    for (int i = 0; i < 5; i++) begin
      rd(ivp_pkg::OFF_PEND, {ivp_pkg::TRAP_BASE_ADDR + 24'(2 * i), 1'b1, 7'(i)}, "trap winner");
      wb(1'b1, ivp_pkg::OFF_TCLR, 32'h1 << i);
    end
    rd(ivp_pkg::OFF_PEND, {24'h000076, 1'b1, 7'h31}, "source after traps");
    // Trap interrupt raised, masked and cleared
    wb(1'b1, ivp_pkg::OFF_FLAG, 32'h0);
    pulse(16'h0000, 5'h04);
    check("trap masked", {31'h0, irq_o}, 32'h0);
    wb(1'b1, ivp_pkg::OFF_TEN, 32'h4);
    check("trap irq", {31'h0, irq_o}, 32'h1);
    wb(1'b1, ivp_pkg::OFF_TCLR, 32'h4);
    rd(ivp_pkg::OFF_TSTAT, 32'h0, "trap cleared");
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    wb(1'b1, 8'h20, 32'h5);
    check("unmapped", {31'h0, er}, 32'h1);
    conclude();
  end
endmodule : ivp_unit_bench

bind ivp_unit ivp_unit_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .adr_i(adr_i), .ack_o(ack_o), .err_o(err_o), .trap_req_i(trap_req_i), .fetch_i(fetch_i),
  .fetch_addr_i(fetch_addr_i), .fetch_data_o(fetch_data_o), .fetch_ack_o(fetch_ack_o),
  .vec_o(vec_o), .irq_o(irq_o));
